// *** logic/aptc_regs.vh ***
// Offsets, field positions, reset values and trigger codes of the pair trigger control
`ifndef APTC_REGS_VH
`define APTC_REGS_VH

// ==========================================================
// Register byte addresses
`define APTC_OFS_CTRL_A    8'h00
`define APTC_OFS_CTRL_B    8'h04
`define APTC_OFS_CTRL_C    8'h08
`define APTC_OFS_STATUS    8'h0c
`define APTC_CTRL_RESET    16'h0000

// ==========================================================
// Fields inside one pair byte
`define APTC_F_IRQ_ALLOW   7
`define APTC_F_WAITING     6
`define APTC_F_SOFT_KICK   5
`define APTC_F_SEL_HI      4
`define APTC_F_SEL_LO      0

// ==========================================================
// Selector codes (index into the trigger vector)
`define APTC_SEL_OFF       5'h00
`define APTC_SEL_OWN_SOFT  5'h01
`define APTC_SEL_GLOBAL    5'h02
`define APTC_SEL_SPECIAL   5'h03
`define APTC_SEL_PRI_1     5'h04
`define APTC_SEL_TMR1      5'h0c
`define APTC_SEL_SEC_SPEC  5'h0d
`define APTC_SEL_SEC_1     5'h0e
`define APTC_SEL_CL_1      5'h17
`define APTC_SEL_TMR2      5'h1f

// ==========================================================
// Bus answers
`define APTC_RESP_OKAY     2'b00
`define APTC_RESP_SLVERR   2'b10

`endif

// *** logic/aptc_pair.v ***
// One converter pair: control byte, waiting flag and completion interrupt
`timescale 1ns/10ps
`default_nettype none
`include "aptc_regs.vh"

module aptc_pair (
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_reset_n,
   // Register access
   input  wire        i_wr,
   input  wire [7:0]  i_wdata,
   output wire [7:0]  o_byte,
   // Shared trigger vector, bits 0 and 1 unused
   input  wire [31:0] i_trig,
   // Converter core
   input  wire        i_done,
   output wire        o_req,
   output wire        o_irq,
   output wire        o_overrun
);

   reg        irq_allow_q;
   reg        waiting_q;
   reg        kick_q;
   reg  [4:0] sel_q;
   reg        irq_q;
   reg        overrun_q;
   reg  [31:0] vec;
   wire       fire;

   // ==========================================================
   // Trigger selection
   // Own soft kick lives in slot 1; slot 0 never fires
   always @* begin
      vec    = i_trig;
      vec[0] = 1'b0;
      vec[1] = kick_q;
   end

   // Triggers are sampled as levels; a held trigger re-arms after done
   assign fire = (sel_q != `APTC_SEL_OFF) && vec[sel_q];

   // ==========================================================
   // Control byte; hardware set of waiting wins over clear and write
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_allow_q <= 1'b0;
         waiting_q   <= 1'b0;
         kick_q      <= 1'b0;
         sel_q       <= 5'h00;
      end else begin
         if (i_wr) begin
            irq_allow_q <= i_wdata[`APTC_F_IRQ_ALLOW];
            sel_q       <= i_wdata[`APTC_F_SEL_HI:`APTC_F_SEL_LO];
         end
         if (fire)
            waiting_q <= 1'b1;
         else if (i_done)
            waiting_q <= 1'b0;
         else if (i_wr)
            waiting_q <= i_wdata[`APTC_F_WAITING];
         if (fire)
            kick_q <= 1'b0;
         else if (i_wr)
            kick_q <= i_wdata[`APTC_F_SOFT_KICK];
      end
   end

   // ==========================================================
   // Completion pulse and overrun marker
   // Done without a posted request is ignored
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_q     <= 1'b0;
         overrun_q <= 1'b0;
      end else begin
         irq_q     <= i_done && waiting_q && irq_allow_q && !fire;
         overrun_q <= fire && waiting_q;
      end
   end

   assign o_byte    = {irq_allow_q, waiting_q, kick_q, sel_q};
   assign o_req     = waiting_q;
   assign o_irq     = irq_q;
   assign o_overrun = overrun_q;

endmodule // aptc_pair

`default_nettype wire

// *** logic/aptc_top.v ***
// Pair trigger control for converter pairs 4, 6, 7, 8, 9 with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "aptc_regs.vh"

module aptc_top (
   // Clock and reset
   input  wire        I_CLK,
   input  wire        I_RESET_N,
   // AXI4-Lite write address
   input  wire        I_AWVALID,
   output wire        O_AWREADY,
   input  wire [7:0]  I_AWADDR,
   // AXI4-Lite write data
   input  wire        I_WVALID,
   output wire        O_WREADY,
   input  wire [31:0] I_WDATA,
   input  wire [3:0]  I_WSTRB,
   // AXI4-Lite write response
   output wire        O_BVALID,
   input  wire        I_BREADY,
   output wire [1:0]  O_BRESP,
   // AXI4-Lite read address
   input  wire        I_ARVALID,
   output wire        O_ARREADY,
   input  wire [7:0]  I_ARADDR,
   // AXI4-Lite read data
   output wire        O_RVALID,
   input  wire        I_RREADY,
   output wire [31:0] O_RDATA,
   output wire [1:0]  O_RRESP,
   // Trigger sources
   input  wire        I_GLOBAL_SOFT,
   input  wire        I_PWM_SPECIAL,
   input  wire        I_PWM_SEC_SPECIAL,
   input  wire [7:0]  I_PWM_PRI_TRIG,
   input  wire [8:0]  I_PWM_SEC_TRIG,
   input  wire [7:0]  I_PWM_CL_TRIG,
   input  wire        I_TMR1_MATCH,
   input  wire        I_TMR2_MATCH,
   // Converter core, bit k = pair 4, 6, 7, 8, 9
   output wire [4:0]  O_CONV_REQ,
   input  wire [4:0]  I_CONV_DONE,
   output wire [4:0]  O_IRQ
);

   // ==========================================================
   // Pair slot to register mapping
   // Slot 0: pair 4 (ch 9/8), register a low byte
   // Slot 1: pair 6 (ch 13/12), register b low byte
   // Slot 2: pair 7 (ch 15/14), register b high byte
   // Slot 3: pair 8 (ch 17/16), register c low byte
   // Slot 4: pair 9 (ch 19/18), register c high byte
   function [7:0] slot_ofs;
      input integer k;
      begin
         if (k == 0)
            slot_ofs = `APTC_OFS_CTRL_A;
         else if (k <= 2)
            slot_ofs = `APTC_OFS_CTRL_B;
         else
            slot_ofs = `APTC_OFS_CTRL_C;
      end
   endfunction

   // Byte lane within the word: odd pairs sit in the high byte
   function slot_lane;
      input integer k;
      begin
         slot_lane = (k == 2) || (k == 4);
      end
   endfunction

   // Address decode shared by the read and write paths
   function addr_mapped;
      input [7:0] a;
      begin
         addr_mapped = (a == `APTC_OFS_CTRL_A) || (a == `APTC_OFS_CTRL_B) ||
                       (a == `APTC_OFS_CTRL_C) || (a == `APTC_OFS_STATUS);
      end
   endfunction

   // ==========================================================
   // Shared trigger vector
   // Index equals selector code, so every pair uses one plain lookup
   wire [31:0] trig_vec;
   assign trig_vec[0]     = 1'b0;
   assign trig_vec[1]     = 1'b0;                 // Own kick inserted per pair
   assign trig_vec[2]     = I_GLOBAL_SOFT;
   assign trig_vec[3]     = I_PWM_SPECIAL;
   assign trig_vec[11:4]  = I_PWM_PRI_TRIG;
   assign trig_vec[12]    = I_TMR1_MATCH;
   assign trig_vec[13]    = I_PWM_SEC_SPECIAL;
   assign trig_vec[22:14] = I_PWM_SEC_TRIG;
   assign trig_vec[30:23] = I_PWM_CL_TRIG;
   assign trig_vec[31]    = I_TMR2_MATCH;

   // ==========================================================
   // Write channel state
   reg        awready_q;
   reg        wready_q;
   reg        aw_hold_q;
   reg        w_hold_q;
   reg  [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg  [3:0] w_strb_q;
   reg        bvalid_q;
   reg  [1:0] bresp_q;
   wire       wr_go;

   // Address and data may arrive in either order; commit once both are held
   assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;

   // ==========================================================
   // Write address, data and response handshakes
   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `APTC_RESP_OKAY;
      end else begin
         // Ready rises one cycle after reset and after each response
         if (!aw_hold_q && !bvalid_q && !awready_q)
            awready_q <= 1'b1;
         if (!w_hold_q && !bvalid_q && !wready_q)
            wready_q <= 1'b1;
         if (I_AWVALID && awready_q) begin
            awready_q <= 1'b0;
            aw_hold_q <= 1'b1;
            aw_addr_q <= I_AWADDR;
         end
         if (I_WVALID && wready_q) begin
            wready_q <= 1'b0;
            w_hold_q <= 1'b1;
            w_data_q <= I_WDATA;
            w_strb_q <= I_WSTRB;
         end
         if (wr_go) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= addr_mapped(aw_addr_q) ? `APTC_RESP_OKAY : `APTC_RESP_SLVERR;
         end else if (bvalid_q && I_BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Pair instances
   wire [7:0] pair_byte [0:4];
   wire [4:0] req_w;
   wire [4:0] irq_w;
   wire [4:0] ovr_w;
   wire [4:0] pair_wr;

   genvar gk;
   generate
      for (gk = 0; gk < 5; gk = gk + 1) begin : g_pair
         // Byte strobe gates each pair independently
         assign pair_wr[gk] = wr_go && (aw_addr_q == slot_ofs(gk)) &&
                              w_strb_q[slot_lane(gk)];
         aptc_pair u_pair (
            .i_clk     (I_CLK),
            .i_reset_n (I_RESET_N),
            .i_wr      (pair_wr[gk]),
            .i_wdata   (slot_lane(gk) ? w_data_q[15:8] : w_data_q[7:0]),
            .o_byte    (pair_byte[gk]),
            .i_trig    (trig_vec),
            .i_done    (I_CONV_DONE[gk]),
            .o_req     (req_w[gk]),
            .o_irq     (irq_w[gk]),
            .o_overrun (ovr_w[gk])
         );
      end
   endgenerate

   // ==========================================================
   // Sticky overrun status: trigger seen while already waiting
   // Write 1 clears; a new overrun in the same cycle wins
   reg  [4:0] overrun_q;
   wire       stat_wr;
   assign stat_wr = wr_go && (aw_addr_q == `APTC_OFS_STATUS) && w_strb_q[0];

   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N)
         overrun_q <= 5'h00;
      else
         overrun_q <= (overrun_q & ~(stat_wr ? w_data_q[4:0] : 5'h00)) | ovr_w;
   end

   // ==========================================================
   // Read path
   reg        arready_q;
   reg        rvalid_q;
   reg [31:0] rdata_q;
   reg  [1:0] rresp_q;
   reg [31:0] rd_word;

   // Unused upper bits read as zero
   always @* begin
      case (I_ARADDR)
         `APTC_OFS_CTRL_A: rd_word = {24'h00_0000, pair_byte[0]};
         `APTC_OFS_CTRL_B: rd_word = {16'h0000, pair_byte[2], pair_byte[1]};
         `APTC_OFS_CTRL_C: rd_word = {16'h0000, pair_byte[4], pair_byte[3]};
         `APTC_OFS_STATUS: rd_word = {19'h0_0000, req_w, 3'h0, overrun_q};
         default:          rd_word = 32'h0000_0000;
      endcase
   end

   // One read in flight; arready drops while data waits for rready
   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `APTC_RESP_OKAY;
      end else begin
         if (I_ARVALID && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= addr_mapped(I_ARADDR) ? `APTC_RESP_OKAY : `APTC_RESP_SLVERR;
         end else if (rvalid_q && I_RREADY) begin
            rvalid_q <= 1'b0;
         end else if (!rvalid_q && !arready_q) begin
            arready_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Outputs, all straight from flip-flops
   assign O_AWREADY  = awready_q;
   assign O_WREADY   = wready_q;
   assign O_BVALID   = bvalid_q;
   assign O_BRESP    = bresp_q;
   assign O_ARREADY  = arready_q;
   assign O_RVALID   = rvalid_q;
   assign O_RDATA    = rdata_q;
   assign O_RRESP    = rresp_q;
   assign O_CONV_REQ = req_w;
   assign O_IRQ      = irq_w;

endmodule // aptc_top

`default_nettype wire

// *** dv/aptc_core_model.sv ***
// Behavioural converter core: one shared converter, lowest pair first
`timescale 1ns/10ps
`default_nettype none
module aptc_core_model (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   // Cycles per conversion, pair handshake
   input  wire logic [3:0] i_lat,
   input  wire logic [4:0] i_req,
   output var  logic [4:0] o_done
);
   logic       busy_q;
   logic [3:0] cnt_q;
   logic [2:0] sel_q, first;
   // Lowest waiting pair wins
   always_comb begin
      first = 3'd0;
      for (int i = 4; i >= 0; i--)
         if (i_req[i]) first = 3'(i);
   end
   // Skip the stale request seen in the cycle of a done strobe
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         busy_q <= 1'b0;
         cnt_q  <= 4'h0;
         sel_q  <= 3'd0;
         o_done <= 5'h00;
      end else begin
         // One-hot strobe, one assignment per edge
         o_done <= (busy_q && cnt_q == 4'h0) ? (5'h01 << sel_q) : 5'h00;
         if (busy_q && cnt_q == 4'h0) begin
            busy_q <= 1'b0;
         end else if (busy_q)
            cnt_q <= cnt_q - 4'h1;
         else if (|i_req && !(|o_done)) begin
            busy_q <= 1'b1;
            sel_q  <= first;
            cnt_q  <= i_lat;
         end
      end
   end
endmodule // aptc_core_model
`default_nettype wire

// *** dv/aptc_assertions.sv ***
// Port checker for the pair trigger control, bound to the top module
`timescale 1ns/10ps
`default_nettype none
module aptc_assertions (
   // Clock and reset
   input wire logic        I_CLK,
   input wire logic        I_RESET_N,
   // Register bus
   input wire logic        I_AWVALID,
   input wire logic        O_AWREADY,
   input wire logic        I_WVALID,
   input wire logic        O_WREADY,
   input wire logic        O_BVALID,
   input wire logic        I_BREADY,
   input wire logic [1:0]  O_BRESP,
   input wire logic        I_ARVALID,
   input wire logic        O_ARREADY,
   input wire logic [7:0]  I_ARADDR,
   input wire logic        O_RVALID,
   input wire logic        I_RREADY,
   input wire logic [31:0] O_RDATA,
   input wire logic [1:0]  O_RRESP,
   // Converter core
   input wire logic [4:0]  O_CONV_REQ,
   input wire logic [4:0]  I_CONV_DONE,
   input wire logic [4:0]  O_IRQ
);
   // ==========================================================
   // Register bus
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);
   a_bresp_holds: assert property (
      O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP)) else $error("bresp moved");
   a_rdata_holds: assert property (
      O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA)) else $error("rdata moved");
   a_write_answer: assert property (
      I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID)
      else $error("no write answer");
   a_read_answer: assert property (
      I_ARVALID && O_ARREADY |=> O_RVALID) else $error("no read answer");
   // Unmapped reads answer zero with an error code
   a_unmapped_read: assert property (
      I_ARVALID && O_ARREADY && !(I_ARADDR inside {8'h00, 8'h04, 8'h08, 8'h0c})
      |=> O_RRESP == 2'b10 && O_RDATA == 32'h0) else $error("unmapped read");
   // ==========================================================
   // Converter pairs
   for (genvar k = 0; k < 5; k++) begin : g_pair
      // Interrupt stands in the cycle after a served done, request gone
      a_irq_cause: assert property (
         O_IRQ[k] |-> $past(I_CONV_DONE[k]) && $past(O_CONV_REQ[k])
         && !O_CONV_REQ[k]) else $error("irq without completion");
      a_irq_pulse: assert property (O_IRQ[k] |=> !O_IRQ[k]) else $error("irq too long");
      // Only a done strobe or a register write may drop a request
      a_req_holds: assert property (
         O_CONV_REQ[k] && !I_CONV_DONE[k] |=> O_CONV_REQ[k] || $rose(O_BVALID))
         else $error("request lost");
   end
   // Main scenarios reached
   cover property (O_IRQ[0]);
   cover property (O_BVALID && O_BRESP == 2'b10);
   cover property (O_CONV_REQ[0] && O_CONV_REQ[4]);
endmodule // aptc_assertions
bind aptc_top aptc_assertions aptc_assertions_inst (.*);
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench: register tasks, trigger bursts and expected results
`timescale 1ns/10ps
`default_nettype none
module tb;
   // ==========================================================
   // Signals
   logic        I_CLK, I_RESET_N, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
   logic [7:0]  I_AWADDR, I_ARADDR, a, b;
   logic [31:0] I_WDATA, trig;
   logic [3:0]  lat, strb;
   logic [4:0]  seen;
   wire         O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
   wire  [1:0]  O_BRESP, O_RRESP;
   wire  [31:0] O_RDATA;
   wire  [4:0]  req, done, irq;
   int          err_count = 0, comparisons = 0, cyc = 0, n, p, sh;
   // Trigger vector bit n is selector code n
   aptc_top aptc_top_inst (
      .I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
      .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_AWADDR(I_AWADDR),
      .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .I_WDATA(I_WDATA), .I_WSTRB(strb),
      .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_BRESP(O_BRESP),
      .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .I_ARADDR(I_ARADDR),
      .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP),
      .I_GLOBAL_SOFT(trig[2]), .I_PWM_SPECIAL(trig[3]), .I_PWM_PRI_TRIG(trig[11:4]),
      .I_TMR1_MATCH(trig[12]), .I_PWM_SEC_SPECIAL(trig[13]),
      .I_PWM_SEC_TRIG(trig[22:14]), .I_PWM_CL_TRIG(trig[30:23]), .I_TMR2_MATCH(trig[31]),
      .O_CONV_REQ(req), .I_CONV_DONE(done), .O_IRQ(irq));
   aptc_core_model aptc_core_model_inst (
      .i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_lat(lat), .i_req(req), .o_done(done));
   // ==========================================================
   // Clock and hang guard
   initial begin
      I_CLK = 1'b0;
      forever #2.5 I_CLK = ~I_CLK;
   end
   always @(posedge I_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   // ==========================================================
   // Compare, bus and trigger tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Address and data offered together, each released when taken
   task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      I_AWADDR <= ad;
      I_WDATA <= d;
      I_AWVALID <= 1'b1;
      I_WVALID <= 1'b1;
      while (!(aw && w)) begin
         @(posedge I_CLK);
         aw = aw || O_AWREADY;
         w = w || O_WREADY;
         I_AWVALID <= !aw;
         I_WVALID <= !w;
      end
      I_BREADY <= 1'b1;
      do @(posedge I_CLK); while (!O_BVALID);
      I_BREADY <= 1'b0;
      check(32'(O_BRESP), 32'(er));
   endtask
   task automatic rchk(input logic [7:0] ad, input logic [31:0] exp, input logic [1:0] er);
      I_ARADDR <= ad;
      I_ARVALID <= 1'b1;
      do @(posedge I_CLK); while (!O_ARREADY);
      I_ARVALID <= 1'b0;
      I_RREADY <= 1'b1;
      do @(posedge I_CLK); while (!O_RVALID);
      I_RREADY <= 1'b0;
      check(O_RDATA, exp);
      check(32'(O_RRESP), 32'(er));
   endtask
   // One-cycle burst, then the request of pair p is compared
   task automatic pulse(input logic [31:0] v, input logic e);
      trig <= v;
      @(posedge I_CLK);
      trig <= 32'h0;
      @(posedge I_CLK);
      check(32'(req[p]), 32'(e));
   endtask
   task report_and_stop;
      if (err_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      I_RESET_N = 1'b0;
      {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 5'h0;
      {I_AWADDR, I_ARADDR, I_WDATA, trig} = 80'h0;
      lat = 4'h3;
      strb = 4'hf;
      repeat (2) @(posedge I_CLK);
      I_RESET_N <= 1'b1;
      @(posedge I_CLK);
      rchk(8'h04, 32'h0, 2'b00);
      rchk(8'h08, 32'h0, 2'b00);
      wr(8'h08, 32'h9fbf, 2'b00);
      rchk(8'h08, 32'h9fbf, 2'b00);
      check(32'(req), 32'h0);
      wr(8'h10, 32'hff, 2'b10);
      rchk(8'h10, 32'h0, 2'b10);
      wr(8'h08, 32'h0, 2'b00);
      // Every selector code on a rotating pair, fast and slow core
      for (int c = 0; c < 32; c++) begin
         p = c % 5;
         sh = (p == 2 || p == 4) ? 8 : 0;
         a = (p == 0) ? 8'h00 : (p < 3) ? 8'h04 : 8'h08;
         b = {c[0], 1'b0, c != 1, 5'(c)};
         lat <= c[1] ? 4'h0 : 4'h7;
         wr(a, 32'(b) << sh, 2'b00);
         pulse(~(32'h3 | (32'h1 << c)), 1'b0);
         if (c == 1) begin
            wr(a, 32'(b | 8'h20) << sh, 2'b00);
            @(posedge I_CLK);
            check(32'(req[p]), 32'h1);
         end else if (c > 1)
            pulse(32'h1 << c, 1'b1);
         for (n = 0; n < 60 && req[p]; n++)
            @(posedge I_CLK);
         // Loop leaves in the one cycle that the interrupt pulse stands
         check(32'(irq[p]), 32'(b[7]));
         rchk(a, 32'(c != 0 ? b & 8'h9f : b) << sh, 2'b00);
         wr(a, 32'h0, 2'b00);
      end
      // Low lane strobe only, then a mid-run reset clears everything
      strb <= 4'h1;
      wr(8'h04, 32'h3f3f, 2'b00);
      strb <= 4'hf;
      rchk(8'h04, 32'h3f, 2'b00);
      I_RESET_N <= 1'b0;
      repeat (2) @(posedge I_CLK);
      I_RESET_N <= 1'b1;
      @(posedge I_CLK);
      rchk(8'h04, 32'h0, 2'b00);
      // Two pairs on one event share the slow converter
      lat <= 4'h9;
      p = 4;
      wr(8'h00, 32'h8c, 2'b00);
      wr(8'h08, 32'h8c00, 2'b00);
      pulse(32'h1000, 1'b1);
      check(32'(req[0]), 32'h1);
      // Second event while both wait: requests stay, overrun marked
      pulse(32'h1000, 1'b1);
      rchk(8'h0c, 32'h1111, 2'b00);
      seen = 5'h0;
      for (n = 0; n < 80 && seen != 5'h11; n++) begin
         @(posedge I_CLK);
         seen = seen | irq;
      end
      check(32'(seen), 32'h11);
      wr(8'h0c, 32'h1f, 2'b00);
      rchk(8'h0c, 32'h0, 2'b00);
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
